/* File: rtl/sodseq_core.sv */
// sodseq_core: turn-on, permanent, offset and AC diagnostic sequencing
// assumes a byte-level serial slave outside decodes writes and reads; comparator
// inputs come from the analog front end and are asynchronous, so are synchronised
`timescale 1ns/1ps

// How it works
// - turn-on pulse runs only at standby exit, when host enabled diagnostics
// - with standby exit and enable together, pulse runs while outputs stay hi-Z
// - turn-on result kept until a new pulse or a diagnostic cycle; a new pulse needs a host read first
// - once biased, go permanent; keep turn-on result until a short appears
// - output status captured at end of pulse top, acquisition about 100 ms
// - restart mode: channels independent, a short shuts only its channel
// - restart mode samples faults every 1 ms, re-enables a clean channel
// - diagnostic mode set by host, self-activates when protection trips
// - after a trip recheck at 1 ms; clean returns, else 100 ms cycle
// - at cycle end faulted channel goes to restart, fault data stored
// - next diagnostic cycle only starts after a host read
// - offset beyond 2 V flagged only if present through whole interval
// - offset interval runs from last read or offset enable to this read
// - offset and AC results suppressed if protection trips in interval
// - AC test enabled by byte two bit 2; bit 7 picks the threshold pair
// - tweeter present only after at least 3 pulses over threshold
// - with several faults at least one reported, others on later reads
// - fault priority: supply short wins, ground short next (open beats a sink-side one), both only with supply and source-side ground
// - open load not detected in permanent diagnostics
// - fault reported only if stable over the whole period before the read
// - every read re-arms cycles and returns the previous cycle's results
// - a read returns four result bytes in sequence
module sodseq_core #(
  parameter int unsigned NCH         = sodseq_pkg::CHANNELS,
  parameter int unsigned RESTART_CYC = sodseq_pkg::RESTART_CYC,
  parameter int unsigned RECHECK_CYC = sodseq_pkg::RECHECK_CYC,
  parameter int unsigned ACQ_CYC     = sodseq_pkg::ACQ_CYC,
  parameter int unsigned DIAG_CYC    = sodseq_pkg::DIAG_CYC
) (
  // clock and reset
  input  wire logic             ref_clk_i,
  input  wire logic             srst_i,
  // instruction bytes from the serial slave
  input  wire logic [7:0]       first_instruction_byte_i,
  input  wire logic [7:0]       second_instruction_byte_i,
  input  wire logic             wr_stb_i,
  // result read from the serial slave
  input  wire logic             rd_start_i,
  input  wire logic [1:0]       rd_idx_i,
  output logic      [7:0]       rd_data_o,
  // analog comparators, asynchronous
  input  wire logic [NCH-1:0]   prot_trip_i,
  input  wire logic [NCH-1:0]   sgnd_so_i,
  input  wire logic [NCH-1:0]   sgnd_test_current_sink_side_i,
  input  wire logic [NCH-1:0]   svs_i,
  input  wire logic [NCH-1:0]   sload_i,
  input  wire logic [NCH-1:0]   open_i,
  input  wire logic [NCH-1:0]   offs_i,
  input  wire logic [NCH-1:0]   ac_pulse_i,
  // power stage control
  output logic                  stby_o,
  output logic                  hiz_o,
  output logic                  test_pulse_o,
  output logic      [NCH-1:0]   ch_en_o,
  output logic                  ac_low_th_o,
  output logic                  line_drv_o,
  output logic                  diag_mode_o,
  output logic                  busy_o
);
  localparam int unsigned CW = 24;
  localparam int unsigned NI = 8;

  typedef enum logic [2:0] {ST_STBY, ST_PULSE, ST_PERM, ST_RECHK, ST_DIAG, ST_HOLD} sodseq_state_e;

  // synchronisers for all comparator inputs, packed together
  logic [NI*NCH-1:0] raw;
  logic [NI*NCH-1:0] s1_q;
  logic [NI*NCH-1:0] s2_q;
  assign raw = {ac_pulse_i, offs_i, open_i, sload_i, svs_i, sgnd_test_current_sink_side_i, sgnd_so_i, prot_trip_i};
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      s1_q <= '0;
      s2_q <= '0;
    end
    else
    begin
      s1_q <= raw;
      s2_q <= s1_q;
    end
  end

  logic [NCH-1:0] trip, gso, gsk, vs, sl, op, ofs, acp;
  assign {acp, ofs, op, sl, vs, gsk, gso, trip} = s2_q;

  function automatic logic [3:0] prio_code(input logic so, input logic sink_side, input logic v,
                                           input logic s, input logic o, input logic allow_open);
    logic [3:0] c;
    c = 4'h0;
    if (v && so)
      c = sodseq_pkg::FC_SHORT_VS | sodseq_pkg::FC_SHORT_GND;
    else if (v)
      c = sodseq_pkg::FC_SHORT_VS;
    else if (so)
      c = sodseq_pkg::FC_SHORT_GND;
    else if (sink_side && o && allow_open)
      c = sodseq_pkg::FC_OPEN_LOAD;
    else if (sink_side)
      c = sodseq_pkg::FC_SHORT_GND;
    else if (s)
      c = sodseq_pkg::FC_SHORT_LOAD;
    else if (o && allow_open)
      c = sodseq_pkg::FC_OPEN_LOAD;
    return c;
  endfunction

  sodseq_state_e   st_q, st_d;
  logic [CW-1:0]   cnt_q, cnt_d;
  logic [CW-1:0]   tick_q, tick_d;
  logic            stby_off_q, stby_off_d;
  logic            armed_q, armed_d;
  logic            diag_en_q, diag_en_d;
  logic            offs_en_q, offs_en_d;
  logic            ac_en_q, ac_en_d;
  logic            ac_low_q, ac_low_d;
  logic            ld_q, ld_d;
  logic [NCH-1:0]  chen_q, chen_d;
  logic [NCH-1:0]  trip_seen_q, trip_seen_d;
  logic [NCH-1:0]  offs_keep_q, offs_keep_d;
  logic [NCH-1:0]  ac_bad_q, ac_bad_d;
  logic [1:0]      acn_q [NCH];
  logic [1:0]      acn_d [NCH];
  logic [NCH-1:0]  acp_q;
  logic [15:0]     fault_q, fault_d;
  logic [15:0]     stab_q, stab_d;
  logic [15:0]     shown_q, shown_d;
  logic            cyc_done_q, cyc_done_d;
  logic            held_q, held_d;
  logic            cap_en;
  logic [31:0]     cap_data;
  logic            tick;
  logic [15:0]     now_code;
  logic            allow_open;

  assign tick       = (tick_q == CW'(RESTART_CYC - 1));
  assign allow_open = (st_q == ST_PULSE);

  always_comb
  begin
    for (int c = 0; c < NCH; c++)
    begin
      now_code[c*4 +: 4] = prio_code(gso[c], gsk[c], vs[c], sl[c], op[c], allow_open);
    end
  end

  always_comb
  begin
    st_d        = st_q;
    cnt_d       = cnt_q;
    tick_d      = tick ? '0 : tick_q + 1'b1;
    stby_off_d  = stby_off_q;
    armed_d     = armed_q;
    diag_en_d   = diag_en_q;
    offs_en_d   = offs_en_q;
    ac_en_d     = ac_en_q;
    ac_low_d    = ac_low_q;
    ld_d        = ld_q;
    chen_d      = chen_q;
    trip_seen_d = trip_seen_q | trip;
    offs_keep_d = offs_keep_q & ofs;
    ac_bad_d    = ac_bad_q;
    acn_d       = acn_q;
    fault_d     = fault_q;
    stab_d      = stab_q;
    shown_d     = shown_q;
    cyc_done_d  = cyc_done_q;
    held_d      = held_q;
    cap_en      = 1'b0;
    // count rising current pulses per channel, saturating at the proof count
    for (int c = 0; c < NCH; c++)
    begin
      if (acp[c] && !acp_q[c] && acn_q[c] != 2'(sodseq_pkg::AC_MIN_PULSES))
        acn_d[c] = acn_q[c] + 2'h1;
    end
    // a fault code survives only while it stays unchanged
    for (int c = 0; c < NCH; c++)
    begin
      // frozen from capture to read, so a read always returns the last cycle
      if (!held_q && now_code[c*4 +: 4] != fault_q[c*4 +: 4])
        stab_d[c*4 +: 4] = 4'h0;
    end
    if (wr_stb_i)
    begin
      diag_en_d = first_instruction_byte_i[sodseq_pkg::B1_DIAG_EN];
      ac_low_d  = second_instruction_byte_i[sodseq_pkg::B2_AC_LOW_TH];
      ld_d      = second_instruction_byte_i[sodseq_pkg::B2_LINE_DRV];
      stby_off_d = second_instruction_byte_i[sodseq_pkg::B2_STBY_OFF];
      if (first_instruction_byte_i[sodseq_pkg::B1_OFFS_EN] && !offs_en_q)
      begin
        offs_keep_d = '1;
        // a trip in this very cycle still counts against the new interval
        trip_seen_d = trip;
      end
      offs_en_d = first_instruction_byte_i[sodseq_pkg::B1_OFFS_EN];
      if (second_instruction_byte_i[sodseq_pkg::B2_AC_EN] && !ac_en_q)
      begin
        for (int c = 0; c < NCH; c++)
          acn_d[c] = 2'h0;
      end
      ac_en_d = second_instruction_byte_i[sodseq_pkg::B2_AC_EN];
    end
    for (int c = 0; c < NCH; c++)
      ac_bad_d[c] = ac_en_q && (acn_q[c] != 2'(sodseq_pkg::AC_MIN_PULSES));
    if (rd_start_i)
    begin
      // hand back last capture, then open a fresh interval for every test
      cap_en      = 1'b1;
      armed_d     = 1'b1;
      cyc_done_d  = 1'b0;
      held_d      = 1'b0;
      offs_keep_d = '1;
      trip_seen_d = trip;
      stab_d      = fault_q & shown_q;
      for (int c = 0; c < NCH; c++)
        acn_d[c] = 2'h0;
    end
    case (st_q)
      ST_STBY:
      begin
        chen_d = '0;
        if (stby_off_d)
        begin
          if (diag_en_d && armed_q)
          begin
            st_d  = ST_PULSE;
            cnt_d = '0;
          end
          else
          begin
            st_d   = ST_PERM;
            chen_d = '1;
          end
        end
      end
      ST_PULSE:
      begin
        cnt_d = cnt_q + 1'b1;
        if (cnt_q == CW'(ACQ_CYC - 1))
        begin
          fault_d  = now_code;
          stab_d   = now_code;
          shown_d  = now_code;
          armed_d  = 1'b0;
          held_d   = 1'b1;
          st_d     = ST_PERM;
          chen_d   = '1;
        end
      end
      ST_PERM:
      begin
        for (int c = 0; c < NCH; c++)
        begin
          // restart mode: each channel on its own, retried every tick
          if (trip[c] && !diag_en_q)
            chen_d[c] = 1'b0;
          // a channel left off by a diagnostic cycle retries the same way
          else if (!chen_q[c] && tick && !trip[c])
            chen_d[c] = 1'b1;
        end
        if (diag_en_q && |trip && !cyc_done_q)
        begin
          st_d  = ST_RECHK;
          cnt_d = '0;
        end
        else if (diag_en_q && |trip)
          chen_d = chen_q & ~trip;
      end
      ST_RECHK:
      begin
        cnt_d = cnt_q + 1'b1;
        if (cnt_q == CW'(RECHECK_CYC - 1))
        begin
          cnt_d = '0;
          st_d  = (|trip) ? ST_DIAG : ST_PERM;
        end
      end
      ST_DIAG:
      begin
        cnt_d = cnt_q + 1'b1;
        if (cnt_q == CW'(DIAG_CYC - 1))
        begin
          // latest short replaces the turn-on result
          fault_d    = now_code;
          stab_d     = now_code;
          shown_d    = now_code;
          chen_d     = chen_q & ~trip;
          cyc_done_d = 1'b1;
          held_d     = 1'b1;
          st_d       = ST_PERM;
        end
      end
      default:
        st_d = ST_STBY;
    endcase
    if (!stby_off_d)
    begin
      st_d   = ST_STBY;
      chen_d = '0;
    end
  end

  // pack four bytes: two of fault codes stable over the period, one of offset and AC, one of flags
  always_comb
  begin
    cap_data = '0;
    cap_data[15:0] = stab_q;
    for (int c = 0; c < NCH; c++)
    begin
      // a trip on any channel voids the whole interval, not just its own flags
      cap_data[16 + c] = offs_en_q && offs_keep_q[c] && !(|trip_seen_q);
      cap_data[20 + c] = ac_bad_q[c] && !(|trip_seen_q);
    end
    cap_data[24] = diag_en_q;
    cap_data[25] = cyc_done_q;
    cap_data[26] = (st_q == ST_PERM);
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      st_q        <= ST_STBY;
      cnt_q       <= '0;
      tick_q      <= '0;
      stby_off_q  <= 1'b0;
      armed_q     <= 1'b1;
      diag_en_q   <= 1'b0;
      offs_en_q   <= 1'b0;
      ac_en_q     <= 1'b0;
      ac_low_q    <= 1'b0;
      ld_q        <= 1'b0;
      chen_q      <= '0;
      trip_seen_q <= '0;
      offs_keep_q <= '0;
      ac_bad_q    <= '0;
      acp_q       <= '0;
      fault_q     <= '0;
      stab_q      <= '0;
      shown_q     <= '0;
      cyc_done_q  <= 1'b0;
      held_q      <= 1'b0;
      for (int c = 0; c < NCH; c++)
        acn_q[c] <= 2'h0;
    end
    else
    begin
      st_q        <= st_d;
      cnt_q       <= cnt_d;
      tick_q      <= tick_d;
      stby_off_q  <= stby_off_d;
      armed_q     <= armed_d;
      diag_en_q   <= diag_en_d;
      offs_en_q   <= offs_en_d;
      ac_en_q     <= ac_en_d;
      ac_low_q    <= ac_low_d;
      ld_q        <= ld_d;
      chen_q      <= chen_d;
      trip_seen_q <= trip_seen_d;
      offs_keep_q <= offs_keep_d;
      ac_bad_q    <= ac_bad_d;
      acp_q       <= acp;
      fault_q     <= fault_d;
      stab_q      <= stab_d;
      shown_q     <= shown_d;
      cyc_done_q  <= cyc_done_d;
      held_q      <= held_d;
      acn_q       <= acn_d;
    end
  end

  // results only land at a read, so the bytes never mix two cycles
  sodseq_result_mem #(
    .DEPTH (sodseq_pkg::RES_BYTES),
    .AW    (2)
  ) u_res (
    .ref_clk_i (ref_clk_i),
    .srst_i    (srst_i),
    .wr_en_i   (cap_en),
    .wr_data_i (cap_data),
    .rd_addr_i (rd_idx_i),
    .rd_data_o (rd_data_o)
  );

  assign stby_o       = (st_q == ST_STBY) || (st_q == ST_PULSE);
  assign hiz_o        = (st_q == ST_PULSE);
  assign test_pulse_o = (st_q == ST_PULSE);
  assign ch_en_o      = chen_q;
  assign ac_low_th_o  = ac_low_q;
  assign line_drv_o   = ld_q;
  assign diag_mode_o  = diag_en_q;
  assign busy_o       = (st_q == ST_RECHK) || (st_q == ST_DIAG);
endmodule

/* File: rtl/sodseq_pkg.sv */
// sodseq_pkg: shared constants for the speaker output diagnostic sequencer
// assumes a 100 MHz reference clock; analog comparators live outside this logic
package sodseq_pkg;
  localparam int unsigned CLK_HZ         = 100_000_000;
  localparam int unsigned CHANNELS       = 4;
  // timing figures in their own units
  localparam int unsigned RESTART_MS     = 1;
  localparam int unsigned RECHECK_MS     = 1;
  localparam int unsigned ACQ_MS         = 100;
  localparam int unsigned DIAG_MS        = 100;
  localparam int unsigned CYC_PER_MS     = CLK_HZ / 1000;
  localparam int unsigned RESTART_CYC    = RESTART_MS * CYC_PER_MS;
  localparam int unsigned RECHECK_CYC    = RECHECK_MS * CYC_PER_MS;
  localparam int unsigned ACQ_CYC        = ACQ_MS * CYC_PER_MS;
  localparam int unsigned DIAG_CYC       = DIAG_MS * CYC_PER_MS;
  // least pulse count that proves a tweeter present
  localparam int unsigned AC_MIN_PULSES  = 3;
  // first instruction byte fields
  localparam int unsigned B1_DIAG_EN     = 6;
  localparam int unsigned B1_OFFS_EN     = 5;
  // second instruction byte fields
  localparam int unsigned B2_AC_LOW_TH   = 7;
  localparam int unsigned B2_STBY_OFF    = 4;
  localparam int unsigned B2_LINE_DRV    = 3;
  localparam int unsigned B2_AC_EN       = 2;
  // fault code per channel, in the result word
  localparam int unsigned FC_W           = 4;
  localparam logic [3:0]  FC_SHORT_GND   = 4'h1;
  localparam logic [3:0]  FC_SHORT_VS    = 4'h2;
  localparam logic [3:0]  FC_SHORT_LOAD  = 4'h4;
  localparam logic [3:0]  FC_OPEN_LOAD   = 4'h8;
  localparam int unsigned RES_BYTES      = 4;
  localparam logic [7:0]  RES_RESET      = 8'h00;
endpackage

/* File: rtl/sodseq_result_mem.sv */
// sodseq_result_mem: four-byte result store, read data registered
// assumes writer and reader share ref_clk_i; all bytes load together
`timescale 1ns/1ps
module sodseq_result_mem #(
  parameter int unsigned DEPTH = 4,
  parameter int unsigned AW    = 2
) (
  // clock and reset
  input  wire logic                ref_clk_i,
  input  wire logic                srst_i,
  // write side
  input  wire logic                wr_en_i,
  input  wire logic [DEPTH*8-1:0]  wr_data_i,
  // read side
  input  wire logic [AW-1:0]       rd_addr_i,
  output logic      [7:0]          rd_data_o
);
  logic [7:0] mem_q [DEPTH];
  logic [7:0] mem_d [DEPTH];
  logic [7:0] rd_q;
  logic [7:0] rd_d;

  always_comb
  begin
    for (int i = 0; i < DEPTH; i++)
    begin
      mem_d[i] = wr_en_i ? wr_data_i[i*8 +: 8] : mem_q[i];
    end
    rd_d = mem_q[rd_addr_i];
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      for (int i = 0; i < DEPTH; i++)
      begin
        mem_q[i] <= sodseq_pkg::RES_RESET;
      end
      rd_q <= sodseq_pkg::RES_RESET;
    end
    else
    begin
      mem_q <= mem_d;
      rd_q  <= rd_d;
    end
  end

  assign rd_data_o = rd_q;
endmodule

/* File: tb/sodseq_host.sv */
// sodseq_host: host controller model issuing instruction writes and result reads
// assumes the core samples on rising edges; drives 1 ns after each edge
`timescale 1ns/1ps
module sodseq_host (
  // clock
  input  wire logic       ref_clk_i,
  // instruction writes
  output logic      [7:0] first_instruction_byte_o,
  output logic      [7:0] second_instruction_byte_o,
  output logic            wr_stb_o,
  // result reads
  output logic            rd_start_o,
  output logic      [1:0] rd_idx_o,
  input  wire logic [7:0] rd_data_i
);
  initial
  begin
    first_instruction_byte_o = 8'h00;
    second_instruction_byte_o = 8'h00;
    wr_stb_o = 1'b0;
    rd_start_o = 1'b0;
    rd_idx_o = 2'h0;
  end

  task automatic write_cfg(input logic [7:0] b1, input logic [7:0] b2);
    @(posedge ref_clk_i);
    #1;
    first_instruction_byte_o = b1;
    second_instruction_byte_o = b2;
    wr_stb_o = 1'b1;
    @(posedge ref_clk_i);
    #1;
    wr_stb_o = 1'b0;
    // bytes are meaningless off the strobe, so show something else
    first_instruction_byte_o = ~b1;
    second_instruction_byte_o = ~b2;
  endtask

  task automatic read_all(output logic [31:0] res);
    @(posedge ref_clk_i);
    #1;
    rd_start_o = 1'b1;
    rd_idx_o = 2'h0;
    @(posedge ref_clk_i);
    #1;
    rd_start_o = 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      @(posedge ref_clk_i);
      #1;
      res[8*i+:8] = rd_data_i;
      rd_idx_o = 2'(i + 1);
    end
  endtask
endmodule

/* File: tb/sodseq_monitor.sv */
// sodseq_monitor: port-level assertions for the diagnostic sequencer
// assumes it is bound to sodseq_core and sees only that module's ports
`timescale 1ns/1ps
module sodseq_monitor #(
  parameter int unsigned NCH     = sodseq_pkg::CHANNELS,
  parameter int unsigned ACQ_CYC = sodseq_pkg::ACQ_CYC
) (
  // clock and reset
  input wire logic           ref_clk_i,
  input wire logic           srst_i,
  // host side
  input wire logic [7:0]     first_instruction_byte_i,
  input wire logic [7:0]     second_instruction_byte_i,
  input wire logic           wr_stb_i,
  input wire logic           rd_start_i,
  input wire logic [1:0]     rd_idx_i,
  input wire logic [7:0]     rd_data_o,
  // power stage side
  input wire logic           stby_o,
  input wire logic           hiz_o,
  input wire logic           test_pulse_o,
  input wire logic [NCH-1:0] ch_en_o,
  input wire logic           ac_low_th_o,
  input wire logic           line_drv_o,
  input wire logic           diag_mode_o,
  input wire logic           busy_o
);
  default clocking mon_cb @(posedge ref_clk_i);
  endclocking
  default disable iff (srst_i);

  logic [31:0] pulse_cnt_q;
  logic [31:0] pulse_cnt_d;

  // counts pulse cycles so the acquisition length can be checked exactly
  always_comb
  begin
    pulse_cnt_d = test_pulse_o ? pulse_cnt_q + 32'h1 : 32'h0;
  end

  always_ff @(posedge ref_clk_i)
  begin
    pulse_cnt_q <= srst_i ? 32'h0 : pulse_cnt_d;
  end

  pulse_hiz_a: assert property (test_pulse_o |-> stby_o && hiz_o && ch_en_o == '0)
    else $error("test pulse outside standby or with outputs driven");
  pulse_cause_a: assert property ($rose(test_pulse_o) |-> $past(wr_stb_i) &&
    $past(first_instruction_byte_i[sodseq_pkg::B1_DIAG_EN]) && $past(second_instruction_byte_i[4]))
    else $error("test pulse without standby exit and diag enable");
  pulse_len_a: assert property ($fell(test_pulse_o) |-> pulse_cnt_q == ACQ_CYC)
    else $error("test pulse length differs from acquisition time");
  stby_exit_a: assert property (wr_stb_i && stby_o && second_instruction_byte_i[4] &&
    !first_instruction_byte_i[6] |=> !stby_o && !test_pulse_o)
    else $error("plain standby exit did not leave standby at once");
  diag_bit_a: assert property (wr_stb_i |=> diag_mode_o == $past(first_instruction_byte_i[6]))
    else $error("diag mode does not follow written enable");
  low_th_a: assert property (wr_stb_i |=> ac_low_th_o == $past(second_instruction_byte_i[7]))
    else $error("ac threshold select does not follow write");
  line_drv_a: assert property (wr_stb_i |=> line_drv_o == $past(second_instruction_byte_i[3]))
    else $error("line driver select does not follow write");
  busy_bound_a: assert property ($rose(busy_o) |-> ##[1:40] !busy_o)
    else $error("recheck plus diagnostic cycle overran");
  busy_diag_a: assert property ($rose(busy_o) |-> diag_mode_o)
    else $error("diagnostic cycle started in restart mode");
  rd_hold_a: assert property (!rd_start_i && !$past(rd_start_i) && $stable(rd_idx_i) |=>
    $stable(rd_data_o))
    else $error("result byte changed without a read");

  cover_pulse: cover property ($fell(test_pulse_o));
  cover_cycle: cover property ($fell(busy_o) && ch_en_o != '1);
  cover_read: cover property (rd_start_i ##2 rd_data_o != 8'h00);
endmodule

bind sodseq_core sodseq_monitor #(.NCH(NCH), .ACQ_CYC(ACQ_CYC)) u_mon (
  .ref_clk_i(ref_clk_i), .srst_i(srst_i), .first_instruction_byte_i(first_instruction_byte_i),
  .second_instruction_byte_i(second_instruction_byte_i), .wr_stb_i(wr_stb_i),
  .rd_start_i(rd_start_i), .rd_idx_i(rd_idx_i), .rd_data_o(rd_data_o), .stby_o(stby_o),
  .hiz_o(hiz_o), .test_pulse_o(test_pulse_o), .ch_en_o(ch_en_o), .ac_low_th_o(ac_low_th_o),
  .line_drv_o(line_drv_o), .diag_mode_o(diag_mode_o), .busy_o(busy_o));

/* File: tb/tb_speaker_output_diagnostic_sequencer.sv */
// tb_speaker_output_diagnostic_sequencer: self-checking bench for sodseq_core
// assumes the host model drives write and read ports; the bench drives comparators
`timescale 1ns/1ps
module tb_speaker_output_diagnostic_sequencer;
  localparam int unsigned ACQ = 20;
  logic        ref_clk_i;
  logic        srst_i;
  logic [7:0]  ib1, ib2, rd_data;
  logic [1:0]  rd_idx;
  logic        wr_stb, rd_start, stby, hiz, tpulse, low_th, line_drv, diag, busy;
  logic [3:0]  prot, sgso, sgsk, svs, sload, openl, offs, acp, ch_en;
  logic [31:0] res;
  int          bad_count, total_checks, cyc;

  always #5 ref_clk_i = ~ref_clk_i;

  sodseq_host host (.ref_clk_i(ref_clk_i), .first_instruction_byte_o(ib1), .second_instruction_byte_o(ib2),
    .wr_stb_o(wr_stb), .rd_start_o(rd_start), .rd_idx_o(rd_idx), .rd_data_i(rd_data));

  // short counts keep the run brief; expectations use the same values
  sodseq_core #(.RESTART_CYC(5), .RECHECK_CYC(5), .ACQ_CYC(ACQ), .DIAG_CYC(20)) DUT (
    .ref_clk_i(ref_clk_i), .srst_i(srst_i), .first_instruction_byte_i(ib1),
    .second_instruction_byte_i(ib2), .wr_stb_i(wr_stb), .rd_start_i(rd_start), .rd_idx_i(rd_idx),
    .rd_data_o(rd_data), .prot_trip_i(prot), .sgnd_so_i(sgso), .sgnd_test_current_sink_side_i(sgsk), .svs_i(svs),
    .sload_i(sload), .open_i(openl), .offs_i(offs), .ac_pulse_i(acp), .stby_o(stby), .hiz_o(hiz),
    .test_pulse_o(tpulse), .ch_en_o(ch_en), .ac_low_th_o(low_th), .line_drv_o(line_drv),
    .diag_mode_o(diag), .busy_o(busy));

  task automatic finish_test();
    if (bad_count == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask

  task automatic wait_busy(input logic v, input int lim);
    for (int i = 0; i < lim && busy !== v; i++)
      step(1);
    chk("busy", 8'(busy), 8'(v));
  endtask

  task automatic wait_en(input logic [3:0] v, input int lim);
    for (int i = 0; i < lim && ch_en !== v; i++)
      step(1);
    chk("ch_en", 8'(ch_en), 8'(v));
  endtask

  task automatic t_turn_on();
    // ch0 open+gnd sink, ch1 gnd source+vs, ch2 gnd sink+vs, ch3 short load+gnd source
    openl = 4'h1;
    sgsk = 4'h5;
    sgso = 4'hA;
    svs = 4'h6;
    sload = 4'h8;
    step(4);
    host.write_cfg(8'h60, 8'h10);
    chk("pulse", 8'({tpulse, hiz, stby}), 8'h07);
    step(ACQ);
    chk("pulse end", 8'({tpulse, stby}), 8'h00);
    chk("ch_en", 8'(ch_en), 8'h0F);
    {openl, sgsk, sgso, svs, sload} = '0;
    host.read_all(res);
    chk("codes01", res[7:0], 8'h38);
    chk("codes23", res[15:8], 8'h12);
    chk("diag flag", 8'(res[24]), 8'h01);
    host.read_all(res);
    chk("codes gone", res[7:0], 8'h00);
  endtask

  task automatic t_restart();
    host.write_cfg(8'h00, 8'h00);
    host.write_cfg(8'h00, 8'h10);
    chk("no pulse", 8'({tpulse, stby, diag}), 8'h00);
    wait_en(4'hF, 4);
    prot = 4'h8;
    wait_en(4'h7, 10);
    chk("busy", 8'(busy), 8'h00);
    step(12);
    chk("still off", 8'(ch_en), 8'h07);
    prot = 4'h0;
    wait_en(4'hF, 15);
  endtask

  task automatic t_perm();
    host.write_cfg(8'h60, 8'h10);
    chk("perm", 8'({tpulse, diag}), 8'h01);
    prot = 4'h2;
    svs = 4'h2;
    wait_busy(1'b1, 10);
    wait_busy(1'b0, 40);
    chk("ch_en", 8'(ch_en), 8'h0D);
    step(30);
    chk("no rearm", 8'(busy), 8'h00);
    host.read_all(res);
    chk("vs code", 8'(res[7:4]), 8'h02);
    wait_busy(1'b1, 10);
    {prot, svs} = '0;
    wait_busy(1'b0, 40);
    wait_en(4'hF, 20);
  endtask

  task automatic t_offset();
    offs = 4'h1;
    host.read_all(res);
    step(30);
    host.read_all(res);
    chk("offset", 8'(res[16]), 8'h01);
    prot = 4'h4;
    step(3);
    prot = 4'h0;
    wait_busy(1'b1, 6);
    wait_busy(1'b0, 12);
    chk("clean", 8'(ch_en), 8'h0F);
    host.read_all(res);
    chk("offs supp", 8'(res[16]), 8'h00);
    step(10);
    offs = 4'h0;
    step(5);
    offs = 4'h1;
    step(10);
    host.read_all(res);
    chk("offs gap", 8'(res[16]), 8'h00);
    offs = 4'h0;
  endtask

  task automatic pulse_ac(input logic [3:0] m);
    acp = m;
    step(4);
    acp = 4'h0;
    step(4);
  endtask

  task automatic t_ac();
    host.write_cfg(8'h40, 8'h94);
    chk("th sel", 8'({low_th, line_drv}), 8'h02);
    host.read_all(res);
    // tone of three cycles on ch0, two on ch1
    pulse_ac(4'h3);
    pulse_ac(4'h3);
    pulse_ac(4'h1);
    host.read_all(res);
    chk("ac open", 8'(res[23:20]), 8'h0E);
    host.read_all(res);
    chk("ac none", 8'(res[23:20]), 8'h0F);
    host.write_cfg(8'h40, 8'h1C);
    chk("line drv", 8'({low_th, line_drv}), 8'h01);
  endtask

  always @(posedge ref_clk_i)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      bad_count++;
      finish_test();
    end
  end

  initial
  begin
    ref_clk_i = 1'b0;
    srst_i = 1'b1;
    {prot, sgso, sgsk, svs, sload, openl, offs, acp} = '0;
    step(8);
    srst_i = 1'b0;
    chk("reset", {stby, hiz, tpulse, ch_en, busy}, 8'h80);
    chk("reset data", rd_data, 8'h00);
    t_turn_on();
    t_restart();
    t_perm();
    t_offset();
    t_ac();
    finish_test();
  end
endmodule
